/* File: pkg/crs_consts.svh */
/*
  Constants of the card register set: command indices, field positions,
  fixed register contents and timing counts.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

`define CRS_CMD_SEND_OP_COND   6'h01
`define CRS_CMD_ALL_SEND_ID    6'h02
`define CRS_CMD_SEND_ID        6'h0A
`define CRS_CMD_SEND_CSD       6'h09
`define CRS_CMD_SEND_STATUS    6'h0D
`define CRS_CMD_PROGRAM_CSD    6'h1B

`define CRS_OCR_BUSY_BIT       31
`define CRS_OCR_LOW_VCCQ_BIT   7
`define CRS_OCR_HIGH_LSB       15
`define CRS_OCR_HIGH_MSB       23
`define CRS_OCR_HIGH_ONES      9'h1FF

`define CRS_CSD_DRIVER_STAGE_PRESENT_BIT    76
`define CRS_CSD_FFG_BIT        15
`define CRS_CSD_COPY_BIT       14
`define CRS_CSD_PERM_BIT       13
`define CRS_CSD_TMP_BIT        12
`define CRS_CSD_FF_LSB         10
`define CRS_CSD_FF_MSB         11
`define CRS_CSD_ECC_LSB        8
`define CRS_CSD_ECC_MSB        9
`define CRS_CSD_CRC_LSB        1
`define CRS_CSD_CRC_MSB        7
`define CRS_HOST_BYTES_MSB     15

`define CRS_ID_MAKER_MSB       127
`define CRS_ID_MAKER_LSB       120
`define CRS_ID_SERIAL_MSB      47
`define CRS_ID_SERIAL_LSB      16

`define CRS_STAT_OK            2'h0
`define CRS_STAT_ILLEGAL       2'h1
`define CRS_STAT_PROG_ERR      2'h2

`define CRS_PWRUP_US           1000
`define CRS_CLK_MHZ            100

`endif

/* File: pkg/crs_pkg.sv */
/*
  Types of the card register set.
  Assumes crs_consts.svh is on the include path.
*/
`include "crs_consts.svh"
package crs_pkg;
  typedef enum logic [1:0] {CRS_ST_IDLE, CRS_ST_READY, CRS_ST_IDENT, CRS_ST_TRAN} crs_state_e;
  typedef logic [127:0] crs_word_t;
endpackage : crs_pkg

/* File: pkg/crs_sync_if.sv */
/*
  Carrier between the host-clock request stage and the core: a toggle handshake.
  Assumes both ends are the crs modules.
*/
`timescale 1ns/100ps
`default_nettype none
interface crs_sync_if;
  logic         req_tgl;
  logic [5:0]   cmd;
  logic [127:0] arg;
  modport src (output req_tgl, output cmd, output arg);
  modport dst (input req_tgl, input cmd, input arg);
endinterface : crs_sync_if
`default_nettype wire

/* File: rtl/crs_link_rx.sv */
/*
  Link-side command capture on the host bus clock: a request toggle with a
  held command word, crossed to the core clock by toggle handshake.
  Assumes the host holds a request strobe for one link clock per command
  and issues no second command before the previous ack toggle returns.
*/
`timescale 1ns/100ps
`default_nettype none
module crs_link_rx (
  input  wire logic         lclk,
  input  wire logic         lrst_n,
  input  wire logic         cmd_valid,
  input  wire logic [5:0]   cmd_index,
  input  wire logic [127:0] cmd_arg,
  output logic              cmd_busy,
  input  wire logic         ack_tgl,
  crs_sync_if.src           bus
);
  typedef struct packed {
    logic         tgl;
    logic [5:0]   cmd;
    logic [127:0] arg;
    logic         ack_s1;
    logic         ack_s2;
  } crs_rx_s;
  crs_rx_s st_reg;
  crs_rx_s st_next;

  always_comb begin
    st_next        = st_reg;
    st_next.ack_s1 = ack_tgl;
    st_next.ack_s2 = st_reg.ack_s1;
    if (cmd_valid && !cmd_busy) begin
      st_next.tgl = ~st_reg.tgl;
      st_next.cmd = cmd_index;
      st_next.arg = cmd_arg;
    end
  end

  always_ff @(posedge lclk) begin
    if (!lrst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmd_busy    = st_reg.tgl != st_reg.ack_s2;
  assign bus.req_tgl = st_reg.tgl;
  assign bus.cmd     = st_reg.cmd;
  assign bus.arg     = st_reg.arg;
endmodule : crs_link_rx
`default_nettype wire

/* File: rtl/crs_card_regs.sv */
/*
  Card register set: operating conditions, identity and card-specific data,
  reached only by protocol commands arriving on the host link clock.
  Assumes command framing and CRC are handled by a separate engine.
*/
`timescale 1ns/100ps
`default_nettype none
`include "crs_consts.svh"
module crs_card_regs #(
  parameter int           PWRUP_CYCLES = `CRS_PWRUP_US * `CRS_CLK_MHZ,
  parameter logic [7:0]   MAKER_CODE   = 8'h5A,
  parameter logic [31:0]  SERIAL_NUM   = 32'h12345678,
  parameter logic [119:0] ID_OTHER     = 120'h0,
  parameter logic [111:0] CSD_UPPER    = 112'h0,
  parameter logic [15:0]  CSD_LOW_INIT = 16'h0001
) (
  input  wire logic         CLK,
  input  wire logic         NRST,
  input  wire logic         CE,
  input  wire logic         LINK_CLK,
  input  wire logic         LINK_NRST,
  input  wire logic         CMD_VALID,
  input  wire logic [5:0]   CMD_INDEX,
  input  wire logic [127:0] CMD_ARG,
  output logic              CMD_BUSY,
  output logic              RESP_VALID,
  output logic [127:0]      RESP_DATA,
  output logic [31:0]       STATUS_WORD
);
  initial begin
    if (PWRUP_CYCLES < 1) $error("PWRUP_CYCLES must be at least one");
  end

  localparam int CW = $clog2(PWRUP_CYCLES + 1);
  // MAKER_CODE and SERIAL_NUM defaults are arbitrary values

  typedef struct packed {
    logic                req_s1;
    logic                req_s2;
    logic                req_seen;
    logic [CW-1:0]       pwr_cnt;
    logic                pwr_done;
    logic [15:0]         csd_low;
    crs_pkg::crs_state_e state;
    logic [1:0]          last_code;
    logic                resp_valid;
    logic [127:0]        resp_data;
    logic                ack;
  } crs_core_s;

  crs_core_s st_reg;
  crs_core_s st_next;
  crs_sync_if sync ();

  crs_link_rx u_rx (
    .lclk      (LINK_CLK),
    .lrst_n    (LINK_NRST),
    .cmd_valid (CMD_VALID),
    .cmd_index (CMD_INDEX),
    .cmd_arg   (CMD_ARG),
    .cmd_busy  (CMD_BUSY),
    .ack_tgl   (st_reg.ack),
    .bus       (sync.src)
  );

  logic [31:0]          ocr_word;
  crs_pkg::crs_word_t   id_word;
  crs_pkg::crs_word_t   csd_word;
  logic                 new_req;
  logic [15:0]          prog;
  logic [15:0]          merged;
  logic                 ro_changed;

  always_comb begin
    ocr_word = 32'h0;
    ocr_word[`CRS_OCR_LOW_VCCQ_BIT] = 1'b1;
    ocr_word[`CRS_OCR_HIGH_MSB:`CRS_OCR_HIGH_LSB] = `CRS_OCR_HIGH_ONES;
    ocr_word[`CRS_OCR_BUSY_BIT] = st_reg.pwr_done;
  end

  always_comb begin
    id_word = {ID_OTHER, 8'h00};
    id_word[`CRS_ID_MAKER_MSB:`CRS_ID_MAKER_LSB]   = MAKER_CODE;
    id_word[`CRS_ID_SERIAL_MSB:`CRS_ID_SERIAL_LSB] = SERIAL_NUM;
    id_word[`CRS_CSD_CRC_MSB:`CRS_CSD_CRC_LSB]     = ID_OTHER[6:0];
    id_word[0] = 1'b1;
  end

  always_comb begin
    // manufacturer bytes above, host bytes below
    csd_word = {CSD_UPPER, st_reg.csd_low};
    csd_word[`CRS_CSD_DRIVER_STAGE_PRESENT_BIT] = 1'b0;
    csd_word[0] = 1'b1;
  end

  always_comb begin
    prog   = sync.arg[`CRS_HOST_BYTES_MSB:0];
    merged = st_reg.csd_low;
    // once-writable fields set only while clear
    merged[`CRS_CSD_FFG_BIT] = st_reg.csd_low[`CRS_CSD_FFG_BIT] | prog[`CRS_CSD_FFG_BIT];
    merged[`CRS_CSD_FF_MSB:`CRS_CSD_FF_LSB] = st_reg.csd_low[`CRS_CSD_FF_MSB:`CRS_CSD_FF_LSB]
                                              | prog[`CRS_CSD_FF_MSB:`CRS_CSD_FF_LSB];
    merged[`CRS_CSD_COPY_BIT] = st_reg.csd_low[`CRS_CSD_COPY_BIT] | prog[`CRS_CSD_COPY_BIT];
    merged[`CRS_CSD_PERM_BIT] = st_reg.csd_low[`CRS_CSD_PERM_BIT] | prog[`CRS_CSD_PERM_BIT];
    merged[`CRS_CSD_TMP_BIT]  = prog[`CRS_CSD_TMP_BIT];
    merged[`CRS_CSD_ECC_MSB:`CRS_CSD_ECC_LSB] = prog[`CRS_CSD_ECC_MSB:`CRS_CSD_ECC_LSB];
    merged[`CRS_CSD_CRC_MSB:`CRS_CSD_CRC_LSB] = prog[`CRS_CSD_CRC_MSB:`CRS_CSD_CRC_LSB];
    merged[0] = 1'b1;
    ro_changed = sync.arg[127:`CRS_HOST_BYTES_MSB+1] != CSD_UPPER;
  end

  always_comb begin
    st_next            = st_reg;
    new_req            = 1'b0;
    st_next.req_s1     = sync.req_tgl;
    st_next.req_s2     = st_reg.req_s1;
    st_next.resp_valid = 1'b0;
    if (!st_reg.pwr_done) begin
      if (st_reg.pwr_cnt == CW'(PWRUP_CYCLES - 1)) begin
        st_next.pwr_done = 1'b1;
      end else begin
        st_next.pwr_cnt = st_reg.pwr_cnt + CW'(1);
      end
    end
    if (st_reg.req_s2 != st_reg.req_seen) begin
      new_req          = 1'b1;
      st_next.req_seen = st_reg.req_s2;
      st_next.ack      = st_reg.req_s2;
    end
    if (new_req) begin
      st_next.resp_valid = 1'b1;
      st_next.last_code  = `CRS_STAT_OK;
      case (sync.cmd)
        `CRS_CMD_SEND_OP_COND: begin
          st_next.resp_data = {96'h0, ocr_word};
          if (st_reg.pwr_done && st_reg.state == crs_pkg::CRS_ST_IDLE) begin
            st_next.state = crs_pkg::CRS_ST_READY;
          end
        end
        `CRS_CMD_ALL_SEND_ID, `CRS_CMD_SEND_ID: begin
          st_next.resp_data = id_word;
          if (st_reg.state == crs_pkg::CRS_ST_READY) begin
            st_next.state = crs_pkg::CRS_ST_IDENT;
          end
        end
        `CRS_CMD_SEND_CSD: begin
          st_next.resp_data = csd_word;
          if (st_reg.state == crs_pkg::CRS_ST_IDENT) begin
            st_next.state = crs_pkg::CRS_ST_TRAN;
          end
        end
        `CRS_CMD_PROGRAM_CSD: begin
          if (ro_changed) begin
            st_next.last_code = `CRS_STAT_PROG_ERR;
          end else begin
            st_next.csd_low = merged;
          end
          st_next.resp_data = {96'h0, 16'h0, st_next.csd_low};
        end
        `CRS_CMD_SEND_STATUS: begin
          st_next.resp_data = {96'h0, STATUS_WORD};
        end
        default: begin
          st_next.last_code = `CRS_STAT_ILLEGAL;
          st_next.resp_data = '0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st_reg         <= '0;
      st_reg.csd_low <= CSD_LOW_INIT;
      st_reg.state   <= crs_pkg::CRS_ST_IDLE;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  assign RESP_VALID = st_reg.resp_valid;
  assign RESP_DATA  = st_reg.resp_data;
  assign STATUS_WORD = {27'h0, st_reg.pwr_done, st_reg.state, st_reg.last_code};
endmodule : crs_card_regs
`default_nettype wire

/* File: test/crs_card_regs_assertions.sv */
/* Checker on the card register set top ports.
   Assumes the host holds index stable until busy drops. */
`timescale 1ns/100ps
`default_nettype none
module crs_chk (
  input wire logic         CLK,
  input wire logic         NRST,
  input wire logic [5:0]   CMD_INDEX,
  input wire logic         RESP_VALID,
  input wire logic [127:0] RESP_DATA,
  input wire logic [31:0]  STATUS_WORD
);
  logic [1:0] lock_reg;
  logic       known;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  assign known = CMD_INDEX inside {6'h01, 6'h02, 6'h0A, 6'h09, 6'h0D, 6'h1B};
  // Copy and permanent lock bits seen set
  always_ff @(posedge CLK) begin
    if (!NRST) lock_reg <= 2'h0;
    else if (RESP_VALID && CMD_INDEX inside {6'h09, 6'h1B} && STATUS_WORD[1:0] == 2'h0)
      lock_reg <= lock_reg | RESP_DATA[14:13];
  end
  AST_OCR_WIN: assert property (RESP_VALID && CMD_INDEX == 6'h01 |->
    RESP_DATA[30:0] == 31'h00FF8080) else $error("op word windows wrong");
  AST_OCR_BUSY: assert property (RESP_VALID && CMD_INDEX == 6'h01 |->
    RESP_DATA[31] == STATUS_WORD[4]) else $error("op word busy bit wrong");
  AST_BIT0: assert property (RESP_VALID && CMD_INDEX inside {6'h02, 6'h0A, 6'h09} |->
    RESP_DATA[0]) else $error("bit zero not one");
  AST_DSR: assert property (RESP_VALID && CMD_INDEX == 6'h09 |-> !RESP_DATA[76])
    else $error("driver stage bit set");
  AST_COPY: assert property (RESP_VALID && CMD_INDEX == 6'h09 && lock_reg[1] |-> RESP_DATA[14])
    else $error("copy flag cleared");
  AST_PERM: assert property (RESP_VALID && CMD_INDEX == 6'h09 && lock_reg[0] |-> RESP_DATA[13])
    else $error("permanent lock cleared");
  AST_ILLEGAL: assert property (RESP_VALID && !known |->
    STATUS_WORD[1:0] == 2'h1 && RESP_DATA == 128'h0) else $error("unknown command answered");
  AST_PULSE: assert property ($rose(RESP_VALID) |=> !RESP_VALID)
    else $error("answer strobe too long");
endmodule : crs_chk
bind crs_card_regs crs_chk chk_u (.CLK(CLK), .NRST(NRST), .CMD_INDEX(CMD_INDEX),
  .RESP_VALID(RESP_VALID), .RESP_DATA(RESP_DATA), .STATUS_WORD(STATUS_WORD));
`default_nettype wire

/* File: test/crs_host_model.sv */
/* Host controller model issuing one command at a time on the link clock.
   Assumes the bench calls send and the link clock runs. */
`timescale 1ns/100ps
`default_nettype none
module crs_host_model (
  input  wire logic    LINK_CLK,
  input  wire logic    CMD_BUSY,
  output logic         CMD_VALID,
  output logic [5:0]   CMD_INDEX,
  output logic [127:0] CMD_ARG
);
  initial begin
    CMD_VALID = 1'b0;
    CMD_INDEX = 6'h3F;
    CMD_ARG   = 128'h0;
  end
  task send(input logic [5:0] idx, input logic [127:0] arg, input int gap);
    int n;
    repeat (gap + 1) @(posedge LINK_CLK);
    #1 CMD_VALID = 1'b1;
    CMD_INDEX = idx;
    CMD_ARG   = arg;
    @(posedge LINK_CLK);
    #1 CMD_VALID = 1'b0;
    n = 0;
    while (CMD_BUSY && n < 64) begin
      @(posedge LINK_CLK);
      #1 n++;
    end
    // Released lines show the inverse
    CMD_INDEX = ~idx;
    CMD_ARG   = ~arg;
  endtask : send
endmodule : crs_host_model
`default_nettype wire

/* File: test/crs_card_regs_bench.sv */
/* Self-checking bench of the card register set.
   Assumes the host model and checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module crs_card_regs_bench;
  logic         clk = 1'b0, lclk = 1'b0, nrst = 1'b0, lnrst = 1'b0;
  logic         busy, valid, rv;
  logic [5:0]   idx;
  logic [127:0] arg, rd, got;
  logic [31:0]  sw, st;
  logic [31:0]  lfsr = 32'h884B1C0B;
  logic [15:0]  low = 16'h0001;
  int           failures = 0, total_checks = 0, n_resp = 0;
  always #5 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  crs_card_regs #(.PWRUP_CYCLES(200), .MAKER_CODE(8'hA5), .SERIAL_NUM(32'h0BAD5EED)) dut_u (
    .CLK(clk), .NRST(nrst), .CE(1'b1), .LINK_CLK(lclk), .LINK_NRST(lnrst), .CMD_VALID(valid),
    .CMD_INDEX(idx), .CMD_ARG(arg), .CMD_BUSY(busy), .RESP_VALID(rv), .RESP_DATA(rd), .STATUS_WORD(sw));
  crs_host_model host_u (.LINK_CLK(lclk), .CMD_BUSY(busy), .CMD_VALID(valid), .CMD_INDEX(idx), .CMD_ARG(arg));
  always @(posedge clk) begin
    if (rv) begin
      got    <= rd;
      st     <= sw;
      n_resp <= n_resp + 1;
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cmd(input logic [5:0] i, input logic [127:0] a);
    int n0;
    n0 = n_resp;
    lfsr = nxt(lfsr);
    host_u.send(i, a, int'(lfsr[1:0]));
    chk(128'(n_resp - n0), 128'h1);
    chk(128'(busy), 128'h0);
  endtask : cmd
  task chk_id;
    cmd(6'h02, {96'h0, lfsr});
    chk(128'({got[127:120], got[47:16], got[0]}), 128'({8'hA5, 32'h0BAD5EED, 1'b1}));
    cmd(6'h0A, 128'h0);
    chk(128'({got[127:120], got[47:16], got[0]}), 128'({8'hA5, 32'h0BAD5EED, 1'b1}));
  endtask : chk_id
  task complete_run;
    $display("Counts: %0d checks, %0d mismatches", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    failures++;
    complete_run;
  end
  initial begin
    logic [15:0] a;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge lclk);
    #1 lnrst = 1'b1;
    cmd(6'h01, 128'hFFFFFFFF);
    chk(128'(got[31:0]), 128'h00FF8080);
    repeat (250) @(posedge clk);
    cmd(6'h01, 128'h0);
    chk(128'(got[31:0]), 128'h80FF8080);
    $display("Test op word done");
    chk_id;
    cmd(6'h09, 128'h0);
    chk(got, {112'h0, low});
    for (int k = 0; k < 8; k++) begin
      lfsr = nxt(lfsr);
      a = (k == 7) ? 16'h0 : lfsr[15:0];
      cmd(6'h1B, {112'h0, a});
      low = (low & 16'hEC00) | a | 16'h0001;
      chk(128'(got[15:0]), 128'(low));
      cmd(6'h09, 128'h0);
      chk(got, {112'h0, low});
    end
    $display("Test programming done");
    cmd(6'h1B, {112'h1, 16'hFFFF});
    chk(128'(st[1:0]), 128'h2);
    cmd(6'h09, 128'h0);
    chk(got, {112'h0, low});
    cmd(6'h3E, {96'h0, lfsr});
    chk(got, 128'h0);
    cmd(6'h0D, 128'h0);
    chk(128'({got[4:0], st[1:0]}), 128'h74);
    chk_id;
    $display("Test refusals done");
    complete_run;
  end
endmodule : crs_card_regs_bench
`default_nettype wire
